/* File: design/cmbf_fabric.sv */
`timescale 1ns/1ps
// How it works
// - Program, primary and secondary paths are independent, so three accesses run at once.
// - A 21-bit program address goes to program memory and its 16-bit word returns to the core.
// - Program memory writes carry only the low 16 bits of the 32-bit core write data.
// - The 24-bit primary address selects byte, word or long data and also reaches mapped I/O.
// - Primary reads return 32 bits and primary writes take 32 bits, both at the primary address.
// - Byte accesses have the top address bit forced to zero.
// - The secondary 24-bit address reads whole words and returns them on a 16-bit bus.
// - Peripheral registers sit on a 16-bit bus at the core rate with no wait states.
// - Peripheral writes use core write data and peripheral reads return on the primary read bus.
module cmbf_fabric #(
  parameter int unsigned PAW = cmbf_pkg::PROG_AW,
  parameter int unsigned XAW = cmbf_pkg::DATA_AW
) (
  input  wire logic                         clk_i,
  input  wire logic                         reset_i,
  input  wire logic                         clk_en_i,
  // Core program side
  input  wire logic                         core_prog_rd_i,
  input  wire logic                         core_prog_wr_i,
  input  wire logic [PAW-1:0]               core_prog_addr_i,
  output logic                              core_prog_valid_o,
  output logic [cmbf_pkg::PROG_DW-1:0]      core_prog_rdata_o,
  // Core primary data side
  input  wire logic                         core_data_rd_i,
  input  wire logic                         core_data_wr_i,
  input  wire logic [1:0]                   core_data_size_i,
  input  wire logic [XAW-1:0]               primary_data_address_i,
  input  wire logic [cmbf_pkg::DATA_DW-1:0] core_wdata_i,
  output logic                              core_data_valid_o,
  output logic [cmbf_pkg::DATA_DW-1:0]      core_data_rdata_o,
  // Core secondary data side
  input  wire logic                         core_sec_rd_i,
  input  wire logic [XAW-1:0]               secondary_data_address_i,
  output logic                              core_sec_valid_o,
  output logic [cmbf_pkg::SEC_DW-1:0]       secondary_read_data_o,
  // Program memory
  output logic                              pmem_rd_o,
  output logic                              pmem_wr_o,
  output logic [PAW-1:0]                    pmem_addr_o,
  output logic [cmbf_pkg::PROG_DW-1:0]      pmem_wdata_o,
  input  wire logic [cmbf_pkg::PROG_DW-1:0] pmem_rdata_i,
  // Primary data memory
  output logic                              xmem_rd_o,
  output logic                              xmem_wr_o,
  output logic [1:0]                        xmem_size_o,
  output logic [XAW-1:0]                    xmem_addr_o,
  output logic [cmbf_pkg::DATA_DW-1:0]      xmem_wdata_o,
  input  wire logic [cmbf_pkg::DATA_DW-1:0] xmem_rdata_i,
  // Secondary data memory port
  output logic                              smem_rd_o,
  output logic [XAW-1:0]                    smem_addr_o,
  input  wire logic [cmbf_pkg::SEC_DW-1:0]  smem_rdata_i,
  // Peripheral register bus
  output logic                              peripheral_register_bus_rd_o,
  output logic                              peripheral_register_bus_wr_o,
  output logic [cmbf_pkg::PERI_AW-1:0]      peripheral_register_bus_addr_o,
  output logic [cmbf_pkg::PERI_DW-1:0]      peripheral_register_bus_wdata_o,
  input  wire logic [cmbf_pkg::PERI_DW-1:0] peripheral_register_bus_rdata_i
);
  logic [XAW-1:0] x_addr;
  logic           x_is_peri;
  logic           x_rd_ret_q;
  logic           x_rd_ret_d;
  logic           peri_sel_q;
  logic           peri_sel_d;
  logic [cmbf_pkg::DATA_DW-1:0] x_ret_data;
  logic           sec_valid;
  logic           data_valid;
  // Requests only count in enabled cycles, so a stall never issues a strobe
  logic           prog_rd_go;
  logic           prog_wr_go;
  logic           data_rd_go;
  logic           data_wr_go;
  logic           sec_rd_go;

  // Byte operands live only in the lower half of data space
  always_comb begin
    x_addr = primary_data_address_i;
    if (core_data_size_i == cmbf_pkg::CMBF_SZ_BYTE) begin
      x_addr[cmbf_pkg::BYTE_MSB] = 1'b0;
    end
  end

  assign x_is_peri = ((x_addr & cmbf_pkg::PERI_MASK) == cmbf_pkg::PERI_BASE);

  // A read wins over a write raised on the same path in the same cycle
  assign prog_rd_go = core_prog_rd_i & clk_en_i;
  assign prog_wr_go = core_prog_wr_i & ~core_prog_rd_i & clk_en_i;
  assign data_rd_go = core_data_rd_i & clk_en_i;
  assign data_wr_go = core_data_wr_i & ~core_data_rd_i & clk_en_i;
  assign sec_rd_go  = core_sec_rd_i & clk_en_i;

  // Program path, always free to run alongside data paths
  assign pmem_rd_o    = prog_rd_go;
  assign pmem_wr_o    = prog_wr_go;
  assign pmem_addr_o  = core_prog_addr_i;
  assign pmem_wdata_o = core_wdata_i[cmbf_pkg::PROG_DW-1:0];

  // Primary path: memory or mapped peripheral, never both
  assign xmem_rd_o    = data_rd_go & ~x_is_peri;
  assign xmem_wr_o    = data_wr_go & ~x_is_peri;
  assign xmem_size_o  = core_data_size_i;
  assign xmem_addr_o  = x_addr;
  assign xmem_wdata_o = core_wdata_i;

  // Peripheral strobes live only in the request cycle, so the core never waits
  assign peripheral_register_bus_rd_o    = data_rd_go & x_is_peri;
  assign peripheral_register_bus_wr_o    = data_wr_go & x_is_peri;
  assign peripheral_register_bus_addr_o  = x_addr[cmbf_pkg::PERI_AW-1:0];
  assign peripheral_register_bus_wdata_o = core_wdata_i[cmbf_pkg::PERI_DW-1:0];

  // Secondary path, word reads only
  assign smem_rd_o   = sec_rd_go;
  assign smem_addr_o = secondary_data_address_i;

  // Remember which target answers the primary read next cycle
  always_comb begin
    x_rd_ret_d = x_rd_ret_q;
    peri_sel_d = peri_sel_q;
    if (clk_en_i) begin
      x_rd_ret_d = core_data_rd_i;
      peri_sel_d = core_data_rd_i & x_is_peri;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      x_rd_ret_q <= 1'b0;
      peri_sel_q <= 1'b0;
    end else begin
      x_rd_ret_q <= x_rd_ret_d;
      peri_sel_q <= peri_sel_d;
    end
  end

  // Peripheral words come back zero-extended in the low half
  always_comb begin
    x_ret_data = xmem_rdata_i;
    if (peri_sel_q) begin
      x_ret_data = {{(cmbf_pkg::DATA_DW-cmbf_pkg::PERI_DW){1'b0}},
                    peripheral_register_bus_rdata_i};
    end
  end

  // Return stages: data one cycle after the request on the program path, two cycles after it on the primary and secondary paths
  // Program memory answers in the request cycle, so its word is staged at once
  cmbf_read_port #(
    .DW (cmbf_pkg::PROG_DW)
  ) u_prog_ret (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .en_i    (clk_en_i),
    .load_i  (core_prog_rd_i),
    .data_i  (pmem_rdata_i),
    .valid_o (core_prog_valid_o),
    .data_o  (core_prog_rdata_o)
  );

  // Memory data arrives the cycle after the request, so stage it then
  cmbf_read_port #(
    .DW (cmbf_pkg::DATA_DW)
  ) u_data_ret (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .en_i    (clk_en_i),
    .load_i  (x_rd_ret_q),
    .data_i  (x_ret_data),
    .valid_o (data_valid),
    .data_o  (core_data_rdata_o)
  );

  // Secondary request flag, held with everything else during a stall
  logic sec_ret_q;
  logic sec_ret_d;

  always_comb begin
    sec_ret_d = sec_ret_q;
    if (clk_en_i) begin
      sec_ret_d = core_sec_rd_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sec_ret_q <= 1'b0;
    end else begin
      sec_ret_q <= sec_ret_d;
    end
  end

  // Same latency as the primary path keeps dual reads aligned
  cmbf_read_port #(
    .DW (cmbf_pkg::SEC_DW)
  ) u_sec_ret (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .en_i    (clk_en_i),
    .load_i  (sec_ret_q),
    .data_i  (smem_rdata_i),
    .valid_o (sec_valid),
    .data_o  (secondary_read_data_o)
  );

  assign core_data_valid_o = data_valid;
  assign core_sec_valid_o  = sec_valid;
endmodule // cmbf_fabric

/* File: design/cmbf_pkg.sv */
package cmbf_pkg;
  localparam int unsigned PROG_AW   = 21;
  localparam int unsigned PROG_DW   = 16;
  localparam int unsigned DATA_AW   = 24;
  localparam int unsigned DATA_DW   = 32;
  localparam int unsigned SEC_DW    = 16;
  localparam int unsigned PERI_DW   = 16;
  localparam int unsigned PERI_AW   = 16;
  // Primary addresses in the 4096-address block at this base go to the peripheral bus
  localparam logic [23:0] PERI_BASE = 24'h00f000;
  localparam logic [23:0] PERI_MASK = 24'hfff000;
  localparam int unsigned BYTE_MSB  = 23;
  // Access sizes on the primary path
  typedef enum logic [1:0] {
    CMBF_SZ_BYTE = 2'h0,
    CMBF_SZ_WORD = 2'h1,
    CMBF_SZ_LONG = 2'h2
  } cmbf_size_t;
  localparam logic [31:0] DATA_RST  = 32'h00000000;
  localparam logic [15:0] HALF_RST  = 16'h0000;
endpackage

/* File: design/cmbf_read_port.sv */
`timescale 1ns/1ps
// Registered read-return stage: holds data and a valid pulse for one path
module cmbf_read_port #(
  parameter int unsigned DW = 16
) (
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  input  wire logic          en_i,
  input  wire logic          load_i,
  input  wire logic [DW-1:0] data_i,
  output logic               valid_o,
  output logic [DW-1:0]      data_o
);
  logic          valid_q;
  logic          valid_d;
  logic [DW-1:0] data_q;
  logic [DW-1:0] data_d;

  always_comb begin
    valid_d = valid_q;
    data_d  = data_q;
    if (en_i) begin
      valid_d = load_i;
      if (load_i) begin
        data_d = data_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      valid_q <= 1'b0;
      data_q  <= '0;
    end else begin
      valid_q <= valid_d;
      data_q  <= data_d;
    end
  end

  assign valid_o = valid_q;
  assign data_o  = data_q;
endmodule // cmbf_read_port

/* File: tb/cmbf_fabric_checker.sv */
`timescale 1ns/1ps
module cmbf_fabric_checker (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        clk_en_i,
  input wire logic        pmem_rd_o,
  input wire logic [15:0] pmem_rdata_i,
  input wire logic        core_prog_valid_o,
  input wire logic [15:0] core_prog_rdata_o,
  input wire logic        xmem_rd_o,
  input wire logic [1:0]  xmem_size_o,
  input wire logic [23:0] xmem_addr_o,
  input wire logic [31:0] xmem_rdata_i,
  input wire logic        core_data_valid_o,
  input wire logic [31:0] core_data_rdata_o,
  input wire logic        smem_rd_o,
  input wire logic        core_sec_valid_o,
  input wire logic        peripheral_register_bus_rd_o,
  input wire logic [15:0] peripheral_register_bus_rdata_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_pvld; pmem_rd_o |=> core_prog_valid_o; endproperty
  a_pvld: assert property (p_pvld) else $error("program valid missing");
  property p_pdat; pmem_rd_o |=> core_prog_rdata_o == $past(pmem_rdata_i); endproperty
  a_pdat: assert property (p_pdat) else $error("program data wrong");
  property p_byte; xmem_rd_o && xmem_size_o == 2'h0 |-> !xmem_addr_o[23]; endproperty
  a_byte: assert property (p_byte) else $error("byte address top bit set");
  property p_xvld; xmem_rd_o ##1 clk_en_i |=> core_data_valid_o; endproperty
  a_xvld: assert property (p_xvld) else $error("data valid missing");
  property p_xdat; xmem_rd_o ##1 clk_en_i |=> core_data_rdata_o == $past(xmem_rdata_i); endproperty
  a_xdat: assert property (p_xdat) else $error("data read wrong");
  property p_svld; smem_rd_o ##1 clk_en_i |=> core_sec_valid_o; endproperty
  a_svld: assert property (p_svld) else $error("secondary valid missing");
  property p_dual; xmem_rd_o && smem_rd_o ##1 clk_en_i |=> core_data_valid_o && core_sec_valid_o;
  endproperty
  a_dual: assert property (p_dual) else $error("dual results split");
  property p_psel; peripheral_register_bus_rd_o |-> !xmem_rd_o; endproperty
  a_psel: assert property (p_psel) else $error("peripheral read reached memory");
  property p_qdat;
    peripheral_register_bus_rd_o ##1 clk_en_i |=> core_data_valid_o &&
      core_data_rdata_o == {16'h0000, $past(peripheral_register_bus_rdata_i)};
  endproperty
  a_qdat: assert property (p_qdat) else $error("peripheral data wrong");
endmodule // cmbf_fabric_checker
bind cmbf_fabric cmbf_fabric_checker cmbf_fabric_checker_inst (.*);

/* File: tb/cmbf_mem_model.sv */
`timescale 1ns/1ps
// Idle registered read buses show the inverse of their last word; the idle program bus inverts its current word
module cmbf_mem_model (
  input  wire logic        clk_i,
  input  wire logic        p_rd_i,
  input  wire logic [20:0] p_addr_i,
  input  wire logic        x_rd_i,
  input  wire logic [23:0] x_addr_i,
  input  wire logic        s_rd_i,
  input  wire logic [23:0] s_addr_i,
  input  wire logic        q_rd_i,
  input  wire logic [15:0] q_addr_i,
  output logic      [15:0] p_rdata_o,
  output logic      [31:0] x_rdata_o,
  output logic      [15:0] s_rdata_o,
  output logic      [15:0] q_rdata_o
);
  assign p_rdata_o = p_rd_i ? p_addr_i[15:0] ^ 16'h5a5a : ~(p_addr_i[15:0] ^ 16'h5a5a);
  always_ff @(posedge clk_i) begin
    x_rdata_o <= x_rd_i ? {8'ha5, x_addr_i} : ~x_rdata_o;
    s_rdata_o <= s_rd_i ? s_addr_i[15:0] ^ 16'h3c3c : ~s_rdata_o;
    q_rdata_o <= q_rd_i ? q_addr_i ^ 16'h0f0f : ~q_rdata_o;
  end
endmodule // cmbf_mem_model

/* File: tb/test_core_memory_bus_fabric.sv */
`timescale 1ns/1ps
module test_core_memory_bus_fabric;
  logic        clk_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1;
  logic        core_prog_rd_i = 1'b0, core_prog_wr_i = 1'b0, core_sec_rd_i = 1'b0;
  logic        core_data_rd_i = 1'b0, core_data_wr_i = 1'b0;
  logic [1:0]  core_data_size_i = 2'h1;
  logic [20:0] core_prog_addr_i = 21'h0;
  logic [23:0] primary_data_address_i = 24'h0, secondary_data_address_i = 24'h0;
  logic [31:0] core_wdata_i = 32'h0;
  logic        core_prog_valid_o, core_data_valid_o, core_sec_valid_o, pmem_rd_o, pmem_wr_o;
  logic        xmem_rd_o, xmem_wr_o, smem_rd_o;
  logic        peripheral_register_bus_rd_o, peripheral_register_bus_wr_o;
  logic [1:0]  xmem_size_o;
  logic [15:0] core_prog_rdata_o, secondary_read_data_o, pmem_wdata_o, pmem_rdata_i;
  logic [15:0] smem_rdata_i, peripheral_register_bus_rdata_i;
  logic [15:0] peripheral_register_bus_addr_o, peripheral_register_bus_wdata_o;
  logic [20:0] pmem_addr_o;
  logic [23:0] xmem_addr_o, smem_addr_o;
  logic [31:0] core_data_rdata_o, xmem_wdata_o, xmem_rdata_i;
  int          error_cnt = 0;
  int          n_compared = 0;
  cmbf_fabric cmbf_fabric_inst (.*);
  cmbf_mem_model cmbf_mem_model_inst (.clk_i, .p_rd_i(pmem_rd_o), .p_addr_i(pmem_addr_o),
    .x_rd_i(xmem_rd_o), .x_addr_i(xmem_addr_o), .s_rd_i(smem_rd_o), .s_addr_i(smem_addr_o),
    .q_rd_i(peripheral_register_bus_rd_o), .q_addr_i(peripheral_register_bus_addr_o),
    .p_rdata_o(pmem_rdata_i), .x_rdata_o(xmem_rdata_i), .s_rdata_o(smem_rdata_i),
    .q_rdata_o(peripheral_register_bus_rdata_i));
  always #10 clk_i = ~clk_i;
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic conclude;
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Top program address read, then a write whose upper data half is dropped
  task automatic t_prog;
    @(posedge clk_i);
    core_prog_addr_i <= 21'h1fffff;
    core_prog_rd_i <= 1'b1;
    @(posedge clk_i);
    core_prog_rd_i <= 1'b0;
    core_prog_wr_i <= 1'b1;
    core_wdata_i <= 32'hdeadbeef;
    #1 chk({core_prog_valid_o, core_prog_rdata_o}, {1'b1, 16'ha5a5});
    chk({pmem_wr_o, pmem_wdata_o}, 17'h1beef);
    @(posedge clk_i);
    core_prog_wr_i <= 1'b0;
  endtask
  // Program, byte primary and secondary reads in one cycle
  task automatic t_dual;
    @(posedge clk_i);
    core_prog_addr_i <= 21'h00155;
    primary_data_address_i <= 24'h801234;
    secondary_data_address_i <= 24'h000abc;
    core_data_size_i <= 2'h0;
    core_prog_rd_i <= 1'b1;
    core_data_rd_i <= 1'b1;
    core_sec_rd_i <= 1'b1;
    #1 chk(xmem_addr_o, 24'h001234);
    chk({pmem_rd_o, pmem_addr_o}, {1'b1, 21'h00155});
    chk({xmem_rd_o, xmem_size_o}, {1'b1, 2'h0});
    chk({smem_rd_o, smem_addr_o}, {1'b1, 24'h000abc});
    @(posedge clk_i);
    core_prog_rd_i <= 1'b0;
    core_data_rd_i <= 1'b0;
    core_sec_rd_i <= 1'b0;
    #1 chk({core_prog_valid_o, core_prog_rdata_o}, {1'b1, 16'h5b0f});
    @(posedge clk_i);
    #1 chk({core_data_valid_o, core_sec_valid_o}, 2'h3);
    chk(core_data_rdata_o, 32'ha5001234);
    chk(secondary_read_data_o, 16'h3680);
  endtask
  // Peripheral write, read, then a long write, all back to back
  task automatic t_peri;
    @(posedge clk_i);
    primary_data_address_i <= 24'h00f012;
    core_data_size_i <= 2'h1;
    core_data_wr_i <= 1'b1;
    core_wdata_i <= 32'hcafe0042;
    #1 chk({peripheral_register_bus_wr_o, xmem_wr_o}, 2'h2);
    chk(peripheral_register_bus_wdata_o, 16'h0042);
    @(posedge clk_i);
    core_data_wr_i <= 1'b0;
    core_data_rd_i <= 1'b1;
    #1 chk(peripheral_register_bus_addr_o, 16'hf012);
    chk({peripheral_register_bus_rd_o, xmem_rd_o}, 2'h2);
    @(posedge clk_i);
    core_data_rd_i <= 1'b0;
    primary_data_address_i <= 24'hfffffc;
    core_data_size_i <= 2'h2;
    core_data_wr_i <= 1'b1;
    #1 chk({xmem_wr_o, xmem_addr_o, xmem_wdata_o}, {1'b1, 24'hfffffc, 32'hcafe0042});
    @(posedge clk_i);
    core_data_wr_i <= 1'b0;
    #1 chk({core_data_valid_o, core_data_rdata_o}, {1'b1, 32'h0000ff1d});
  endtask
  // Requests raised while stalled wait, and results hold while stalled
  task automatic t_stall;
    @(posedge clk_i);
    clk_en_i <= 1'b0;
    core_prog_addr_i <= 21'h00100;
    primary_data_address_i <= 24'h000100;
    secondary_data_address_i <= 24'h000100;
    core_data_size_i <= 2'h1;
    core_prog_rd_i <= 1'b1;
    core_data_rd_i <= 1'b1;
    core_sec_rd_i <= 1'b1;
    #1 chk({pmem_rd_o, xmem_rd_o, smem_rd_o}, 3'h0);
    @(posedge clk_i);
    clk_en_i <= 1'b1;
    #1 chk({core_prog_valid_o, core_data_valid_o, core_sec_valid_o}, 3'h0);
    @(posedge clk_i);
    core_prog_rd_i <= 1'b0;
    core_data_rd_i <= 1'b0;
    core_sec_rd_i <= 1'b0;
    #1 chk({core_prog_valid_o, core_prog_rdata_o}, {1'b1, 16'h5b5a});
    @(posedge clk_i);
    clk_en_i <= 1'b0;
    #1 chk({core_data_valid_o, core_sec_valid_o}, 2'h3);
    chk({core_data_rdata_o, secondary_read_data_o}, {32'ha5000100, 16'h3d3c});
    @(posedge clk_i);
    clk_en_i <= 1'b1;
    #1 chk({core_data_valid_o, core_sec_valid_o}, 2'h3);
    @(posedge clk_i);
    #1 chk({core_data_valid_o, core_sec_valid_o}, 2'h0);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    t_prog();
    t_dual();
    t_peri();
    t_stall();
    conclude();
  end
endmodule // test_core_memory_bus_fabric
